// [logic/usdp_pkg.sv]
// constants and types for the shadow receive/transmit data port
// assumes a 32-bit apb master and an external serializer/deserializer
package usdp_pkg;
  localparam logic [31:0] SHADOW_BASE = 32'h5000_1130;
  localparam logic [31:0] SHADOW_1_ADDR = 32'h5000_1134;
  localparam logic [31:0] SHADOW_2_ADDR = 32'h5000_1138;
  localparam logic [31:0] SHADOW_SPAN = 32'h0000_0040;
  localparam logic [31:0] CTRL_ADDR = 32'h5000_1170;
  localparam logic [31:0] LSTAT_ADDR = 32'h5000_1174;
  localparam logic [31:0] ISTAT_ADDR = 32'h5000_1178;
  localparam logic [31:0] IMASK_ADDR = 32'h5000_117c;
  localparam int DEFAULT_FIFO_DEPTH = 16;
  localparam int CTRL_FIFO_EN_BIT = 0;
  localparam int CTRL_IR_MODE_BIT = 1;
  localparam int LS_DR_BIT = 0;
  localparam int LS_OE_BIT = 1;
  localparam int LS_TX_HOLDING_EMPTY_FLAG_BIT = 5;
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_OVR_BIT = 1;
  localparam int IRQ_TX_HOLDING_EMPTY_FLAG_BIT = 2;
  localparam logic CTRL_FIFO_EN_RESET = 1'b0;
  localparam logic CTRL_IR_MODE_RESET = 1'b0;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam logic [7:0] DATA_RESET = 8'h00;

  typedef struct packed {
    logic ir_mode;
    logic fifo_en;
  } usdp_ctrl_s;
endpackage

// [logic/usdp_uart_shadow_data_port.sv]
// apb slave for the shadow data window with receive and transmit fifos
// assumes byte streams from/to a serial framer; pins are synchronous to I_CLK
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps

// Function
// - sixteen shadow words all read the receive buffer head
// - a write to any shadow word acts as a transmit holding write
// - received byte comes from the uart or infrared input by mode
// - without fifos a new byte overwrites unread data and flags overrun
// - with fifos a data read returns and pops the fifo head
// - full receive fifo keeps contents, drops new byte, flags overrun
// - without fifos one write clears the holding empty flag
// - without fifos further writes overwrite the pending transmit byte
// - with fifos up to the fifo depth bytes are accepted
// - writes to a full transmit fifo are dropped
// - transmit data goes to the uart or infrared output by mode
module usdp_uart_shadow_data_port
  import usdp_pkg::*;
#(
  parameter int FIFO_DEPTH = DEFAULT_FIFO_DEPTH
) (
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [31:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_UART_RX_VALID,
  input wire logic [7:0] I_UART_RX_DATA,
  input wire logic I_IR_RX_VALID,
  input wire logic [7:0] I_IR_RX_DATA,
  output logic O_UART_TX_VALID,
  output logic O_IR_TX_VALID,
  output logic [7:0] O_TX_DATA,
  input wire logic I_TX_TAKE,
  output logic O_IRQ
);
  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  typedef logic [PW-1:0] usdp_ptr_t;
  typedef logic [CW-1:0] usdp_cnt_t;

  function automatic usdp_ptr_t ptr_inc(input usdp_ptr_t p);
    ptr_inc = (p == PW'(FIFO_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  function automatic logic in_shadow(input logic [31:0] a);
    logic [31:0] off;
    off = a - SHADOW_BASE;
    in_shadow = (a >= SHADOW_BASE) && (off < SHADOW_SPAN) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic addr_mapped(input logic [31:0] a);
    addr_mapped = in_shadow(a) || (a == CTRL_ADDR) || (a == LSTAT_ADDR) ||
                  (a == ISTAT_ADDR) || (a == IMASK_ADDR);
  endfunction

  usdp_ctrl_s ctrl_reg;
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic [7:0] rx_mem [FIFO_DEPTH];
  logic [7:0] tx_mem [FIFO_DEPTH];
  usdp_ptr_t rx_rd_reg, rx_wr_reg, tx_rd_reg, tx_wr_reg;
  usdp_cnt_t rx_cnt_reg, tx_cnt_reg, rx_cnt_next, tx_cnt_next;
  logic ovr_reg;
  logic [2:0] ist_reg, imask_reg, ist_next;
  logic irq_reg;
  logic uart_tx_valid_reg, ir_tx_valid_reg;
  logic [7:0] tx_data_reg;
  logic [31:0] rdata_next;

  // apb decode; every transfer answers in its first access cycle, with no wait cycle
  logic setup, access, wr_acc, rd_acc, wr_data, rd_data, rd_lstat, rd_istat, wr_ctrl, flush;
  assign setup = I_PSEL & ~I_PENABLE;
  assign access = I_PSEL & I_PENABLE & pready_reg;
  assign wr_acc = access & I_PWRITE & addr_mapped(I_PADDR);
  assign rd_acc = access & ~I_PWRITE;
  assign wr_data = wr_acc & in_shadow(I_PADDR) & I_PSTRB[0];
  assign rd_data = rd_acc & in_shadow(I_PADDR);
  assign rd_lstat = rd_acc & (I_PADDR == LSTAT_ADDR);
  assign rd_istat = rd_acc & (I_PADDR == ISTAT_ADDR);
  assign wr_ctrl = wr_acc & (I_PADDR == CTRL_ADDR) & I_PSTRB[0];
  // switching fifo mode empties both buffers so old pointers never mix with the new capacity
  assign flush = wr_ctrl & (I_PWDATA[CTRL_FIFO_EN_BIT] != ctrl_reg.fifo_en);

  // receive path
  logic rx_in_valid, rx_full, rx_pop, rx_space, rx_push, rx_over, rx_lost;
  logic [7:0] rx_in_data, rx_head;
  usdp_cnt_t rx_cap, tx_cap;
  assign rx_in_valid = ctrl_reg.ir_mode ? I_IR_RX_VALID : I_UART_RX_VALID;
  assign rx_in_data = ctrl_reg.ir_mode ? I_IR_RX_DATA : I_UART_RX_DATA;
  assign rx_cap = ctrl_reg.fifo_en ? CW'(FIFO_DEPTH) : CW'(1);
  assign rx_full = (rx_cnt_reg == rx_cap);
  assign rx_pop = rd_data & (rx_cnt_reg != '0) & ~flush;
  assign rx_space = ~rx_full | rx_pop;
  assign rx_push = rx_in_valid & rx_space & ~flush;
  assign rx_over = rx_in_valid & ~rx_space & ~ctrl_reg.fifo_en & ~flush;
  assign rx_lost = rx_in_valid & ~rx_space & ctrl_reg.fifo_en & ~flush;
  assign rx_head = rx_mem[rx_rd_reg];
  assign rx_cnt_next = flush ? '0 : rx_cnt_reg + CW'(rx_push) - CW'(rx_pop);

  always_ff @(posedge I_CLK) begin
    if (rx_push) begin
      rx_mem[rx_wr_reg] <= rx_in_data;
    end else if (rx_over) begin
      rx_mem[rx_rd_reg] <= rx_in_data;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rx_rd_reg <= '0;
      rx_wr_reg <= '0;
      rx_cnt_reg <= '0;
    end else if (flush) begin
      rx_rd_reg <= '0;
      rx_wr_reg <= '0;
      rx_cnt_reg <= '0;
    end else begin
      if (rx_push) begin
        rx_wr_reg <= ptr_inc(rx_wr_reg);
      end
      if (rx_pop) begin
        rx_rd_reg <= ptr_inc(rx_rd_reg);
      end
      rx_cnt_reg <= rx_cnt_next;
    end
  end

  // transmit path
  logic tx_full, tx_take, tx_space, tx_push, tx_over, tx_empty_ev;
  usdp_ptr_t tx_rd_n;
  logic [7:0] tx_head_next;
  assign tx_cap = ctrl_reg.fifo_en ? CW'(FIFO_DEPTH) : CW'(1);
  assign tx_full = (tx_cnt_reg == tx_cap);
  assign tx_take = I_TX_TAKE & (uart_tx_valid_reg | ir_tx_valid_reg) & (tx_cnt_reg != '0) & ~flush;
  assign tx_space = ~tx_full | tx_take;
  assign tx_push = wr_data & tx_space & ~flush;
  // a full fifo drops the write outright, a single holding byte is replaced instead
  assign tx_over = wr_data & ~tx_space & ~ctrl_reg.fifo_en & ~flush;
  assign tx_rd_n = tx_take ? ptr_inc(tx_rd_reg) : tx_rd_reg;
  assign tx_cnt_next = flush ? '0 : tx_cnt_reg + CW'(tx_push) - CW'(tx_take);
  assign tx_head_next = (tx_over || (tx_push && tx_wr_reg == tx_rd_n)) ? I_PWDATA[7:0] : tx_mem[tx_rd_n];
  assign tx_empty_ev = (tx_cnt_reg != '0) & (tx_cnt_next == '0);

  always_ff @(posedge I_CLK) begin
    if (tx_push) begin
      tx_mem[tx_wr_reg] <= I_PWDATA[7:0];
    end else if (tx_over) begin
      tx_mem[tx_rd_reg] <= I_PWDATA[7:0];
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      tx_rd_reg <= '0;
      tx_wr_reg <= '0;
      tx_cnt_reg <= '0;
    end else if (flush) begin
      tx_rd_reg <= '0;
      tx_wr_reg <= '0;
      tx_cnt_reg <= '0;
    end else begin
      if (tx_push) begin
        tx_wr_reg <= ptr_inc(tx_wr_reg);
      end
      tx_rd_reg <= tx_rd_n;
      tx_cnt_reg <= tx_cnt_next;
    end
  end

  // serializer sees the head byte from the same edge that stores it, built from next-state values
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      uart_tx_valid_reg <= 1'b0;
      ir_tx_valid_reg <= 1'b0;
      tx_data_reg <= DATA_RESET;
    end else begin
      uart_tx_valid_reg <= (tx_cnt_next != '0) & ~ctrl_reg.ir_mode;
      ir_tx_valid_reg <= (tx_cnt_next != '0) & ctrl_reg.ir_mode;
      tx_data_reg <= (tx_cnt_next != '0) ? tx_head_next : DATA_RESET;
    end
  end

  // control, mask and sticky flags; a new event beats a clearing read
  assign ist_next = (rd_istat ? 3'h0 : ist_reg) |
                    {tx_empty_ev, rx_over | rx_lost, rx_push};

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ctrl_reg <= '{ir_mode: CTRL_IR_MODE_RESET, fifo_en: CTRL_FIFO_EN_RESET};
      imask_reg <= IRQ_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg.fifo_en <= I_PWDATA[CTRL_FIFO_EN_BIT];
      ctrl_reg.ir_mode <= I_PWDATA[CTRL_IR_MODE_BIT];
    end else if (wr_acc && I_PADDR == IMASK_ADDR && I_PSTRB[0]) begin
      imask_reg <= I_PWDATA[2:0];
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ist_reg <= IRQ_RESET;
      ovr_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      ist_reg <= ist_next;
      ovr_reg <= (rd_lstat ? 1'b0 : ovr_reg) | rx_over | rx_lost;
      irq_reg <= |(ist_next & imask_reg);
    end
  end

  // read data is fetched in the setup cycle and held through the access cycle
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (in_shadow(I_PADDR)) begin
      rdata_next[7:0] = (rx_cnt_reg != '0) ? rx_head : DATA_RESET;
    end else if (I_PADDR == LSTAT_ADDR) begin
      rdata_next[LS_DR_BIT] = (rx_cnt_reg != '0);
      rdata_next[LS_OE_BIT] = ovr_reg;
      rdata_next[LS_TX_HOLDING_EMPTY_FLAG_BIT] = (tx_cnt_reg == '0);
    end else if (I_PADDR == CTRL_ADDR) begin
      rdata_next[CTRL_FIFO_EN_BIT] = ctrl_reg.fifo_en;
      rdata_next[CTRL_IR_MODE_BIT] = ctrl_reg.ir_mode;
    end else if (I_PADDR == ISTAT_ADDR) begin
      rdata_next[2:0] = ist_reg;
    end else if (I_PADDR == IMASK_ADDR) begin
      rdata_next[2:0] = imask_reg;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      prdata_reg <= (setup & ~I_PWRITE) ? rdata_next : 32'h0000_0000;
      pslverr_reg <= setup & ~addr_mapped(I_PADDR);
    end
  end

  assign O_PREADY = pready_reg;
  assign O_PRDATA = prdata_reg;
  assign O_PSLVERR = pslverr_reg;
  assign O_UART_TX_VALID = uart_tx_valid_reg;
  assign O_IR_TX_VALID = ir_tx_valid_reg;
  assign O_TX_DATA = tx_data_reg;
  assign O_IRQ = irq_reg;

  sequence s_shadow_read_setup;
    setup && !I_PWRITE && in_shadow(I_PADDR) && rx_cnt_reg != '0;
  endsequence

  sequence s_shadow_answer(logic [7:0] b);
    O_PREADY && O_PRDATA == {24'h0, b};
  endsequence

  property p_rx_alias;
    logic [7:0] b;
    @(posedge I_CLK) disable iff (!I_RESET_N)
    (s_shadow_read_setup, b = rx_head) |=> s_shadow_answer(b);
  endproperty
  a_rx_alias: assert property (p_rx_alias) else $error("shadow read did not return receive head");

  property p_tx_alias;
    @(posedge I_CLK) disable iff (!I_RESET_N)
    wr_data && tx_cnt_reg == '0 && !flush |=> (O_UART_TX_VALID || O_IR_TX_VALID) && O_TX_DATA == $past(I_PWDATA[7:0]);
  endproperty
  a_tx_alias: assert property (p_tx_alias) else $error("shadow write did not reach transmit holding");

  property p_rx_mode_sel;
    @(posedge I_CLK) disable iff (!I_RESET_N)
    ctrl_reg.ir_mode && I_IR_RX_VALID && rx_cnt_reg == '0 && !flush |=> rx_cnt_reg == 1 && rx_head == $past(I_IR_RX_DATA);
  endproperty
  a_rx_mode_sel: assert property (p_rx_mode_sel) else $error("infrared byte not captured in infrared mode");

  property p_rx_overwrite;
    @(posedge I_CLK) disable iff (!I_RESET_N)
    !ctrl_reg.fifo_en && rx_cnt_reg == 1 && rx_in_valid && !rx_pop && !flush
      |=> rx_cnt_reg == 1 && rx_head == $past(rx_in_data) && ovr_reg;
  endproperty
  a_rx_overwrite: assert property (p_rx_overwrite) else $error("non-fifo receive overwrite or overrun wrong");

  property p_rx_pop;
    @(posedge I_CLK) disable iff (!I_RESET_N)
    rd_data && rx_cnt_reg != '0 && !rx_in_valid && !flush |=> rx_cnt_reg == $past(rx_cnt_reg) - 1'b1;
  endproperty
  a_rx_pop: assert property (p_rx_pop) else $error("data read did not pop receive fifo");

  property p_rx_full_drop;
    @(posedge I_CLK) disable iff (!I_RESET_N)
    ctrl_reg.fifo_en && rx_full && rx_in_valid && !rx_pop && !flush
      |=> $stable(rx_cnt_reg) && $stable(rx_head) && ovr_reg && ist_reg[IRQ_OVR_BIT];
  endproperty
  a_rx_full_drop: assert property (p_rx_full_drop) else $error("full receive fifo changed or no overrun");

  property p_tx_holding_empty_flag_clear;
    @(posedge I_CLK) disable iff (!I_RESET_N)
    !ctrl_reg.fifo_en && tx_cnt_reg == '0 && wr_data && !flush |=> tx_cnt_reg == 1 ##1 tx_cnt_reg != '0 || $past(tx_take);
  endproperty
  a_tx_holding_empty_flag_clear: assert property (p_tx_holding_empty_flag_clear) else $error("holding empty not cleared by write");

  property p_tx_overwrite;
    @(posedge I_CLK) disable iff (!I_RESET_N)
    !ctrl_reg.fifo_en && tx_cnt_reg == 1 && wr_data && !tx_take && !flush
      |=> tx_cnt_reg == 1 && O_TX_DATA == $past(I_PWDATA[7:0]);
  endproperty
  a_tx_overwrite: assert property (p_tx_overwrite) else $error("pending transmit byte not overwritten");

  property p_tx_fill;
    @(posedge I_CLK) disable iff (!I_RESET_N)
    ctrl_reg.fifo_en && !tx_full && wr_data && !tx_take && !flush |=> tx_cnt_reg == $past(tx_cnt_reg) + 1'b1;
  endproperty
  a_tx_fill: assert property (p_tx_fill) else $error("transmit fifo refused a byte below depth");

  property p_tx_full_drop;
    @(posedge I_CLK) disable iff (!I_RESET_N)
    ctrl_reg.fifo_en && tx_full && wr_data && !tx_take && !flush |=> $stable(tx_cnt_reg) && $stable(O_TX_DATA);
  endproperty
  a_tx_full_drop: assert property (p_tx_full_drop) else $error("write to full transmit fifo not dropped");

  property p_tx_route;
    @(posedge I_CLK) disable iff (!I_RESET_N)
    (O_UART_TX_VALID || O_IR_TX_VALID) |-> O_IR_TX_VALID == $past(ctrl_reg.ir_mode) && !(O_UART_TX_VALID && O_IR_TX_VALID);
  endproperty
  a_tx_route: assert property (p_tx_route) else $error("transmit byte on wrong output for mode");

  property p_rsvd_zero;
    @(posedge I_CLK) disable iff (!I_RESET_N)
    O_PREADY && I_PSEL && !I_PWRITE && in_shadow(I_PADDR) |-> O_PRDATA[31:8] == 24'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved shadow bits not zero");
endmodule // usdp_uart_shadow_data_port

// [verif/usdp_framer_model.sv]
// framer model: feeds received bytes, takes transmit bytes
// assumes the shadow data port pins, all on one clock
`timescale 1ns/1ps
module usdp_framer_model (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_take_en,
  input wire logic i_uart_tx_valid,
  input wire logic i_ir_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_uart_rx_valid,
  output logic o_ir_rx_valid,
  output logic [7:0] o_uart_rx_data,
  output logic [7:0] o_ir_rx_data,
  output logic o_tx_take
);
  logic req_reg = 1'b0;
  logic ir_reg = 1'b0;
  logic [7:0] byte_reg = 8'h00;
  logic [7:0] idle_reg = 8'h00;
  logic [7:0] got_q[$];
  // idle data wanders so a stale byte never looks fresh
  assign o_uart_rx_valid = req_reg & !ir_reg;
  assign o_ir_rx_valid = req_reg & ir_reg;
  assign o_uart_rx_data = o_uart_rx_valid ? byte_reg : idle_reg;
  assign o_ir_rx_data = o_ir_rx_valid ? byte_reg : ~idle_reg;
  task automatic send(input logic ir, input logic [7:0] b);
    @(posedge i_clk);
    req_reg <= 1'b1;
    ir_reg <= ir;
    byte_reg <= b;
    @(posedge i_clk);
    req_reg <= 1'b0;
  endtask
  always @(posedge i_clk) idle_reg <= idle_reg + 8'h01;
  // takes every other cycle at most, slower than the port allows
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_tx_take <= 1'b0;
    end else begin
      if (o_tx_take && (i_uart_tx_valid || i_ir_tx_valid)) got_q.push_back(i_tx_data);
      o_tx_take <= i_take_en && !o_tx_take && (i_uart_tx_valid || i_ir_tx_valid);
    end
  end
endmodule // usdp_framer_model

// [verif/tb_top.sv]
// testbench: apb register tasks and framer model around the data port
// assumes one 100 mhz clock and the package address map
`timescale 1ns/1ps
module tb_top;
  import usdp_pkg::*;
  localparam int DEPTH = 16;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic take_en = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, urv, irv, utv, itv, take, irq;
  logic [7:0] urd, ird, txd;
  logic [31:0] rv;
  logic ev;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  usdp_uart_shadow_data_port #(.FIFO_DEPTH(DEPTH)) dut (.I_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_UART_RX_VALID(urv), .I_UART_RX_DATA(urd),
    .I_IR_RX_VALID(irv), .I_IR_RX_DATA(ird), .O_UART_TX_VALID(utv), .O_IR_TX_VALID(itv), .O_TX_DATA(txd),
    .I_TX_TAKE(take), .O_IRQ(irq));
  usdp_framer_model fm (.i_clk(clk), .i_reset_n(rst_n), .i_take_en(take_en), .i_uart_tx_valid(utv),
    .i_ir_tx_valid(itv), .i_tx_data(txd), .o_uart_rx_valid(urv), .o_ir_rx_valid(irv), .o_uart_rx_data(urd),
    .o_ir_rx_data(ird), .o_tx_take(take));
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // holds the request until pready is sampled high, then releases
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no local limit: a slave that never answers runs into the cycle ceiling
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic wait_got(input int cnt);
    while (fm.got_q.size() < cnt) begin
      @(posedge clk);
    end
    settle();
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(CTRL_ADDR, 32'h0);
    rd(SHADOW_BASE, 32'h0);
    rd(LSTAT_ADDR, 32'h20);
    fm.send(1'b0, 8'h5a);
    rd(LSTAT_ADDR, 32'h21);
    fm.send(1'b0, 8'ha5);
    rd(LSTAT_ADDR, 32'h23);
    chk(irq, 1'b0);
    apb(1'b1, IMASK_ADDR, 32'h3);
    settle();
    chk(irq, 1'b1);
    rd(ISTAT_ADDR, 32'h3);
    settle();
    chk(irq, 1'b0);
    rd(SHADOW_BASE + 32'h3c, 32'ha5);
    rd(LSTAT_ADDR, 32'h20);
    apb(1'b0, SHADOW_BASE - 32'h4, 32'h0);
    chk(ev, 1'b1);
    chk(rv, 32'h0);
    apb(1'b1, CTRL_ADDR, 32'h3);
    fm.send(1'b0, 8'h99);
    for (int i = 0; i < DEPTH; i++) fm.send(1'b1, 8'(8'h10 + i));
    fm.send(1'b1, 8'hee);
    rd(LSTAT_ADDR, 32'h23);
    rd(ISTAT_ADDR, 32'h3);
    for (int i = 0; i < DEPTH; i++) rd(SHADOW_BASE + 32'(4 * i), 32'h10 + 32'(i));
    rd(SHADOW_BASE, 32'h0);
    apb(1'b1, CTRL_ADDR, 32'h1);
    for (int i = 0; i < DEPTH; i++) apb(1'b1, SHADOW_BASE + 32'(4 * i), 32'hffff_ff40 + 32'(i));
    rd(LSTAT_ADDR, 32'h0);
    apb(1'b1, SHADOW_BASE, 32'h99);
    pstrb <= 4'he;
    apb(1'b1, SHADOW_BASE, 32'h98);
    pstrb <= 4'hf;
    chk(utv, 1'b1);
    chk(itv, 1'b0);
    take_en <= 1'b1;
    wait_got(DEPTH);
    chk(32'(fm.got_q.size()), DEPTH);
    for (int i = 0; i < DEPTH; i++) chk(fm.got_q[i], 32'h40 + 32'(i));
    rd(ISTAT_ADDR, 32'h4);
    fm.got_q.delete();
    apb(1'b1, CTRL_ADDR, 32'h2);
    take_en <= 1'b0;
    apb(1'b1, SHADOW_BASE + 32'h24, 32'h77);
    rd(LSTAT_ADDR, 32'h0);
    apb(1'b1, SHADOW_BASE + 32'h28, 32'h88);
    // strobe for the data byte low: this write must leave the pending byte alone
    pstrb <= 4'he;
    apb(1'b1, SHADOW_BASE, 32'h66);
    pstrb <= 4'hf;
    settle();
    chk(txd, 8'h88);
    chk(itv, 1'b1);
    chk(utv, 1'b0);
    @(posedge clk);
    take_en <= 1'b1;
    wait_got(1);
    chk(32'(fm.got_q.size()), 32'h1);
    chk(fm.got_q[0], 32'h88);
    rd(LSTAT_ADDR, 32'h20);
    end_of_test();
  end
endmodule // tb_top
